//--- rtl/pbm_pkg.sv
// constants and types of the peripheral bus protocol monitor
// Operation
// - violation shown as 6-bit code, ones when clean
// - lowest priority number wins over all others
// - write data change before acknowledge flagged
// - address change before acknowledge flagged
// - direction, select, byte enable changes flagged
// - nonzero address or data while unselected
// - acknowledge, error, retry while unselected flagged
// - acknowledge missing sixteen cycles after select
// - retry with acknowledge, or retry too long
// - select, lock, request linger after retry
// - direction, suppress, timeout while unselected flagged
// - multiple grants, or grant to non-owner
// - bad lock rise, or grant while locked
// - unheld master select, or multiple selects
// - byte enables misaligned or not contiguous
// - sequential address without lock, select, increment
// - sequential address without transaction boundary
// - arbiter timeout missing after sixteen silent cycles
// - sixteen trigger groups watched at once
// - trigger output fifteen cycles after inputs
// - combined data group is read OR write
// - shared control and per-master control groups
package pbm_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int N_MST = 16;
    localparam int N_UNIT = 16;
    localparam int N_VIOL = 32;
    localparam int GRP_W = 32;
    localparam int CODE_W = 6;
    localparam int BE_W = 4;
    localparam int CNT_W = 5;
    localparam int GRP_SEL_W = 5;
    localparam int MST_IDX_W = 4;

    // ------------------------------------------------------------
    // codes and timing
    // ------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_NONE = 6'h3f;
    localparam logic [CNT_W-1:0] ACK_LIMIT = 5'h10;
    localparam logic [CNT_W-1:0] NORESP_LIMIT = 5'h10;
    localparam int TRIG_LAT = 15;
    localparam int TRIG_DLY = TRIG_LAT - 1;
    localparam logic [31:0] ADDR_STEP = 32'h4;
    localparam logic [BE_W-1:0] BE_LANE0 = 4'h1;
    localparam logic [N_VIOL-1:0] VIOL_ONE = 32'h1;

    // violations in priority order, first is highest
    typedef enum logic [4:0] {
        V_DBUS_CHG, V_ABUS_CHG, V_ABUS_IDLE, V_DBUS_IDLE,
        V_ACK_IDLE, V_ACK_LATE, V_ERR_IDLE, V_RTY_ACK,
        V_RTY_LONG, V_GNT_MULTI, V_GNT_NOWN, V_LOCK_NOGNT,
        V_LOCK_GNT, V_RTY_SEL, V_RTY_IDLE, V_SEL_NOWN,
        V_SEL_MULTI, V_RNW_IDLE, V_RNW_CHG, V_SEL_CHG,
        V_BE_CHG, V_BE_ALIGN, V_BE_GAP, V_RTY_REQ,
        V_RTY_LOCK, V_SEQ_NOLOCK, V_SEQ_IDLE, V_SEQ_INC,
        V_SEQ_NOBND, V_TSUP_IDLE, V_TOUT_MISS, V_TOUT_IDLE
    } pbm_viol_e;

    // code of each violation, indexed by pbm_viol_e
    localparam logic [N_VIOL-1:0][CODE_W-1:0] PBM_CODE_TAB = {
        6'h0b, 6'h0a, 6'h18, 6'h14, 6'h13, 6'h12, 6'h11, 6'h05,
        6'h06, 6'h1f, 6'h1e, 6'h1d, 6'h1c, 6'h1b, 6'h10, 6'h0f,
        6'h0e, 6'h09, 6'h08, 6'h03, 6'h02, 6'h01, 6'h00, 6'h07,
        6'h04, 6'h17, 6'h16, 6'h15, 6'h0d, 6'h0c, 6'h19, 6'h1a
    };

    // ------------------------------------------------------------
    // trigger group selectors
    // ------------------------------------------------------------
    localparam logic [GRP_SEL_W-1:0] GRP_CTRL = 5'h00;
    localparam logic [GRP_SEL_W-1:0] GRP_ADDR = 5'h01;
    localparam logic [GRP_SEL_W-1:0] GRP_DATA = 5'h02;
    localparam logic [GRP_SEL_W-1:0] GRP_RD = 5'h03;
    localparam logic [GRP_SEL_W-1:0] GRP_WR = 5'h04;
    localparam logic [GRP_SEL_W-1:0] GRP_PV = 5'h05;
    localparam logic [GRP_SEL_W-1:0] GRP_GEN = 5'h06;
    localparam logic [GRP_SEL_W-1:0] GRP_MST0 = 5'h07;
    localparam logic [GRP_SEL_W-1:0] GRP_MST_END = 5'h17;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef logic [GRP_W-1:0] pbm_grp_t;

    // 17-bit shared control group
    typedef struct packed {
        logic sys_rst;
        logic debugger_system_reset;
        logic watchdog_reset;
        logic bus_rst;
        logic [BE_W-1:0] be;
        logic select;
        logic xfer_ack;
        logic rnw;
        logic err_ack;
        logic timeout;
        logic tout_sup;
        logic retry;
        logic seq_addr;
        logic bus_lock;
    } pbm_ctrl_t;

    typedef struct packed {
        pbm_ctrl_t ctrl;
        logic [GRP_W-1:0] abus;
        logic [GRP_W-1:0] rd_dbus;
        logic [GRP_W-1:0] wr_dbus;
    } pbm_bus_t;

    // 11-bit per-master control group
    typedef struct packed {
        logic request;
        logic grant;
        logic pend_req;
        logic lock;
        logic [BE_W-1:0] be;
        logic master_select;
        logic rnw;
        logic seq_addr;
    } pbm_mst_t;

    typedef struct packed {
        logic en;
        logic [GRP_SEL_W-1:0] sel;
        logic [GRP_W-1:0] value;
        logic [GRP_W-1:0] mask;
    } pbm_match_cfg_t;

endpackage : pbm_pkg

//--- rtl/pbm_delay_line.sv
// fixed-depth single-bit delay line
`timescale 1ns/1ps
module pbm_delay_line #(
    parameter int DEPTH = 14
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic d_i,
    output logic q_o
);

    typedef struct packed {
        logic [DEPTH-1:0] sh;
    } pbm_dly_st_t;

    pbm_dly_st_t st_q;
    pbm_dly_st_t st_d;

    // shift one place per edge
    always_comb begin
        st_d = st_q;
        st_d.sh = {st_q.sh[DEPTH-2:0], d_i};
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_o = st_q.sh[DEPTH-1];

endmodule : pbm_delay_line

//--- rtl/pbm_match_unit.sv
// one trigger match unit: masked compare of a group word
`timescale 1ns/1ps
module pbm_match_unit
    import pbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire pbm_grp_t data_i,
    input wire pbm_match_cfg_t cfg_i,
    output logic hit_o
);

    typedef struct packed {
        logic hit;
    } pbm_mu_st_t;

    pbm_mu_st_t st_q;
    pbm_mu_st_t st_d;

    // hit when every unmasked bit equals the value
    always_comb begin
        st_d = st_q;
        st_d.hit = cfg_i.en &&
                   (((data_i ^ cfg_i.value) & cfg_i.mask) == '0);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit_o = st_q.hit;

endmodule : pbm_match_unit

//--- rtl/pbm_monitor.sv
// bus protocol monitor and trigger front end
`timescale 1ns/1ps
module pbm_monitor
    import pbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire pbm_bus_t bus_i,
    input wire pbm_mst_t [N_MST-1:0] mst_i,
    input wire logic [GRP_W-1:0] generic_trigger_input_i,
    input wire pbm_match_cfg_t [N_UNIT-1:0] cfg_i,
    input wire logic trig_any_i,
    output logic [CODE_W-1:0] violation_code_o,
    output logic trigger_output_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [GRP_W-1:0] abus;
        logic [GRP_W-1:0] wdbus;
        logic [BE_W-1:0] be;
        logic rnw;
        logic open;
        logic retry;
        logic lock;
        logic seq;
        logic ack;
        logic [N_MST-1:0] grant;
        logic [N_MST-1:0] mlock;
        logic [N_MST-1:0] msel;
        logic [N_MST-1:0] retried;
        logic [CNT_W-1:0] ack_cnt;
        logic [CNT_W-1:0] nr_cnt;
        logic [CODE_W-1:0] code;
    } pbm_mon_st_t;

    pbm_mon_st_t st_q;
    pbm_mon_st_t st_d;
    logic [N_VIOL-1:0] viol;
    logic [N_MST-1:0] grant_v;
    logic [N_MST-1:0] req_v;
    logic [N_MST-1:0] mlock_v;
    logic [N_MST-1:0] msel_v;
    logic msel_any;
    logic [GRP_W-1:0] dbus;
    logic [BE_W-1:0] be_low;
    logic [BE_W-1:0] be_sum;
    logic noresp;
    logic [N_UNIT-1:0] hit;
    pbm_grp_t [N_UNIT-1:0] grp_v;
    logic [N_UNIT-1:0] en_v;
    logic trig_now;

    // ------------------------------------------------------------
    // bus views
    // ------------------------------------------------------------
    // gather per-master bits into vectors
    always_comb begin
        for (int i = 0; i < N_MST; i++) begin
            grant_v[i] = mst_i[i].grant;
            req_v[i] = mst_i[i].request;
            mlock_v[i] = mst_i[i].lock;
            msel_v[i] = mst_i[i].master_select;
        end
    end

    assign msel_any = |msel_v;
    assign dbus = bus_i.rd_dbus | bus_i.wr_dbus;
    assign be_low = bus_i.ctrl.be & (~bus_i.ctrl.be + BE_LANE0);
    assign be_sum = bus_i.ctrl.be + be_low;
    assign noresp = bus_i.ctrl.select && !bus_i.ctrl.xfer_ack &&
                    !bus_i.ctrl.err_ack && !bus_i.ctrl.retry &&
                    !bus_i.ctrl.tout_sup;

    // true when no violation of higher priority is present
    // the vector is an argument, so assertions see its sampled value
    function automatic logic hi_clr(input logic [N_VIOL-1:0] v,
                                    input pbm_viol_e idx);
        return (v & ((VIOL_ONE << idx) - VIOL_ONE)) == '0;
    endfunction : hi_clr

    // ------------------------------------------------------------
    // violation checks and encoder
    // ------------------------------------------------------------
    // the monitor only reads the bus, never drives it
    always_comb begin
        logic [CODE_W-1:0] code;
        code = CODE_NONE;
        st_d = st_q;
        viol = '0;
        // stability while a transfer awaits its acknowledge
        viol[V_DBUS_CHG] = st_q.open && !st_q.rnw &&
                           bus_i.wr_dbus != st_q.wdbus;
        viol[V_ABUS_CHG] = st_q.open &&
                           bus_i.abus != st_q.abus;
        viol[V_RNW_CHG] = st_q.open &&
                          bus_i.ctrl.rnw != st_q.rnw;
        viol[V_SEL_CHG] = st_q.open && !bus_i.ctrl.select;
        viol[V_BE_CHG] = st_q.open &&
                         bus_i.ctrl.be != st_q.be;
        // activity with no master selected
        viol[V_ABUS_IDLE] = !msel_any && bus_i.abus != '0;
        viol[V_DBUS_IDLE] = !msel_any && dbus != '0;
        viol[V_ACK_IDLE] = !msel_any && bus_i.ctrl.xfer_ack;
        viol[V_ERR_IDLE] = !msel_any && bus_i.ctrl.err_ack;
        viol[V_RTY_IDLE] = !msel_any && bus_i.ctrl.retry;
        viol[V_RNW_IDLE] = !msel_any && bus_i.ctrl.rnw;
        viol[V_TSUP_IDLE] = !msel_any &&
                            bus_i.ctrl.tout_sup;
        viol[V_TOUT_IDLE] = !msel_any &&
                            bus_i.ctrl.timeout;
        // slow acknowledge and missing arbiter timeout
        viol[V_ACK_LATE] = bus_i.ctrl.select && !bus_i.ctrl.xfer_ack &&
                           st_q.ack_cnt == ACK_LIMIT;
        viol[V_TOUT_MISS] = noresp && !bus_i.ctrl.timeout &&
                            st_q.nr_cnt == NORESP_LIMIT;
        // retry handling
        viol[V_RTY_ACK] = bus_i.ctrl.retry &&
                          bus_i.ctrl.xfer_ack;
        viol[V_RTY_LONG] = bus_i.ctrl.retry && st_q.retry;
        viol[V_RTY_SEL] = st_q.retry && bus_i.ctrl.select;
        viol[V_RTY_LOCK] = st_q.retry &&
                           bus_i.ctrl.bus_lock;
        viol[V_RTY_REQ] = st_q.retry &&
                          |(req_v & st_q.retried);
        // arbitration and locking
        viol[V_GNT_MULTI] = $countones(grant_v) > 1;
        viol[V_GNT_NOWN] = |(grant_v & ~req_v);
        viol[V_LOCK_NOGNT] = bus_i.ctrl.bus_lock && !st_q.lock &&
                             st_q.grant == '0 &&
                             !bus_i.ctrl.select;
        viol[V_LOCK_GNT] = st_q.lock && bus_i.ctrl.bus_lock &&
                           |(grant_v & ~st_q.mlock);
        viol[V_SEL_NOWN] = |(msel_v & ~(st_q.grant | st_q.msel |
                                         st_q.mlock));
        viol[V_SEL_MULTI] = $countones(msel_v) > 1;
        // byte enable shape
        viol[V_BE_ALIGN] = bus_i.ctrl.select &&
                           bus_i.ctrl.be != '0 &&
                           be_low != (BE_LANE0 << bus_i.abus[1:0]);
        // the line above the gap check follows
        viol[V_BE_GAP] = bus_i.ctrl.select && bus_i.ctrl.be != '0 &&
                         (be_sum & bus_i.ctrl.be) != '0;
        // sequential addressing
        viol[V_SEQ_NOLOCK] = bus_i.ctrl.seq_addr &&
                             !bus_i.ctrl.bus_lock;
        viol[V_SEQ_IDLE] = bus_i.ctrl.seq_addr && !msel_any;
        viol[V_SEQ_INC] = st_q.seq && st_q.ack && bus_i.ctrl.select &&
                          bus_i.abus != st_q.abus + ADDR_STEP;
        viol[V_SEQ_NOBND] = bus_i.ctrl.seq_addr && !st_q.seq &&
                            st_q.open;
        // lowest index wins, scan from the bottom of the list up
        for (int i = N_VIOL - 1; i >= 0; i--) begin
            if (viol[i]) begin
                code = PBM_CODE_TAB[i];
            end
        end
        st_d.code = code;
        // history for the next cycle's checks
        st_d.abus = bus_i.abus;
        st_d.wdbus = bus_i.wr_dbus;
        st_d.be = bus_i.ctrl.be;
        st_d.rnw = bus_i.ctrl.rnw;
        st_d.open = bus_i.ctrl.select && !bus_i.ctrl.xfer_ack &&
                    !bus_i.ctrl.err_ack && !bus_i.ctrl.retry &&
                    !bus_i.ctrl.timeout;
        st_d.retry = bus_i.ctrl.retry;
        st_d.lock = bus_i.ctrl.bus_lock;
        st_d.seq = bus_i.ctrl.seq_addr;
        st_d.ack = bus_i.ctrl.xfer_ack;
        st_d.grant = grant_v;
        st_d.mlock = mlock_v;
        st_d.msel = msel_v;
        if (bus_i.ctrl.retry) begin
            st_d.retried = msel_v;
        end
        // cycles of select without acknowledge, saturating
        if (!bus_i.ctrl.select || bus_i.ctrl.xfer_ack) begin
            st_d.ack_cnt = '0;
        end else if (st_q.ack_cnt != ACK_LIMIT) begin
            st_d.ack_cnt = st_q.ack_cnt + 1'b1;
        end
        // cycles with no slave response, saturating
        if (!noresp) begin
            st_d.nr_cnt = '0;
        end else if (st_q.nr_cnt != NORESP_LIMIT) begin
            st_d.nr_cnt = st_q.nr_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
            st_q.code <= CODE_NONE;
        end else begin
            st_q <= st_d;
        end
    end

    assign violation_code_o = st_q.code;

    // ------------------------------------------------------------
    // trigger groups and match units
    // ------------------------------------------------------------
    // pick one trigger group word by selector
    function automatic pbm_grp_t grp_pick(
        input logic [GRP_SEL_W-1:0] sel
    );
        logic [MST_IDX_W-1:0] m;
        m = MST_IDX_W'(sel - GRP_MST0);
        if (sel == GRP_CTRL) begin
            return pbm_grp_t'(bus_i.ctrl);
        end else if (sel == GRP_ADDR) begin
            return bus_i.abus;
        end else if (sel == GRP_DATA) begin
            return dbus;
        end else if (sel == GRP_RD) begin
            return bus_i.rd_dbus;
        end else if (sel == GRP_WR) begin
            return bus_i.wr_dbus;
        end else if (sel == GRP_PV) begin
            return pbm_grp_t'(st_q.code);
        end else if (sel == GRP_GEN) begin
            return generic_trigger_input_i;
        end else if (sel >= GRP_MST0 && sel < GRP_MST_END) begin
            return pbm_grp_t'(mst_i[m]);
        end else begin
            return '0;
        end
    endfunction : grp_pick

    // group word of each unit; a process, so every bus read wakes it
    always_comb begin
        for (int u = 0; u < N_UNIT; u++) begin
            grp_v[u] = grp_pick(cfg_i[u].sel);
        end
    end

    // sixteen units, each watching a group of its own
    for (genvar u = 0; u < N_UNIT; u++) begin : g_unit
        pbm_match_unit u_match (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .data_i(grp_v[u]),
            .cfg_i(cfg_i[u]),
            .hit_o(hit[u])
        );
        assign en_v[u] = cfg_i[u].en;
    end

    // any-of or all-of the enabled units
    assign trig_now = trig_any_i ? |(hit & en_v) :
                      (&(hit | ~en_v)) && (|en_v);

    // unit register plus delay line gives the full latency
    pbm_delay_line #(
        .DEPTH(TRIG_DLY)
    ) u_delay (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i(trig_now),
        .q_o(trigger_output_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_NONE_CODE: assert property (@(posedge clk_i) disable iff (srst_i)
        viol == '0 |=> violation_code_o == CODE_NONE)
        else $error("clean cycle did not give the no-error code");

    AST_PRIO: assert property (@(posedge clk_i) disable iff (srst_i)
        viol[V_ABUS_IDLE] && viol[V_DBUS_IDLE] && hi_clr(viol, V_ABUS_IDLE)
        |=> violation_code_o == PBM_CODE_TAB[V_ABUS_IDLE])
        else $error("lower priority violation was reported");

    AST_DBUS_CHG: assert property (@(posedge clk_i) disable iff (srst_i)
        st_q.open && !st_q.rnw && $changed(bus_i.wr_dbus) |=>
        violation_code_o == PBM_CODE_TAB[V_DBUS_CHG])
        else $error("write data change not reported");

    AST_ABUS_CHG: assert property (@(posedge clk_i) disable iff (srst_i)
        st_q.open && $changed(bus_i.abus) && hi_clr(viol, V_ABUS_CHG) |=>
        violation_code_o == PBM_CODE_TAB[V_ABUS_CHG])
        else $error("address change not reported");

    AST_ACK_LATE: assert property (@(posedge clk_i) disable iff (srst_i)
        st_q.ack_cnt == ACK_LIMIT && bus_i.ctrl.select &&
        !bus_i.ctrl.xfer_ack && hi_clr(viol, V_ACK_LATE) |=>
        violation_code_o == PBM_CODE_TAB[V_ACK_LATE])
        else $error("late acknowledge not reported");

    AST_RTY_ACK: assert property (@(posedge clk_i) disable iff (srst_i)
        bus_i.ctrl.retry && bus_i.ctrl.xfer_ack && hi_clr(viol, V_RTY_ACK)
        |=> violation_code_o == PBM_CODE_TAB[V_RTY_ACK])
        else $error("retry with acknowledge not reported");

    AST_RTY_SEL: assert property (@(posedge clk_i) disable iff (srst_i)
        bus_i.ctrl.retry ##1 (bus_i.ctrl.select && hi_clr(viol, V_RTY_SEL))
        |=> violation_code_o == PBM_CODE_TAB[V_RTY_SEL])
        else $error("select after retry not reported");

    AST_GNT_MULTI: assert property (@(posedge clk_i) disable iff (srst_i)
        $countones(grant_v) > 1 && hi_clr(viol, V_GNT_MULTI) |=>
        violation_code_o == PBM_CODE_TAB[V_GNT_MULTI])
        else $error("multiple grants not reported");

    AST_SEL_MULTI: assert property (@(posedge clk_i) disable iff (srst_i)
        $countones(msel_v) > 1 && hi_clr(viol, V_SEL_MULTI) |=>
        violation_code_o == PBM_CODE_TAB[V_SEL_MULTI])
        else $error("multiple master selects not reported");

    // samples taken while reset was high are not compared
    AST_TRIG_LAT: assert property (@(posedge clk_i) disable iff (srst_i)
        !$past(srst_i, TRIG_DLY) |->
        trigger_output_o == $past(trig_now, TRIG_DLY))
        else $error("trigger output latency is wrong");

endmodule : pbm_monitor

//--- tb/pbm_bus_model.sv
// partner model: one master, the arbiter and one slave doing single writes
`timescale 1ns/1ps
module pbm_bus_model
    import pbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic go_i,
    input wire logic [5:0] wait_i,
    input wire logic [3:0] be_i,
    input wire logic [31:0] addr_i,
    output logic busy_o,
    output pbm_bus_t bus_o,
    output pbm_mst_t [N_MST-1:0] mst_o
);
    logic [1:0] ph_q;
    logic [5:0] cnt_q;

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    // grant cycle, then select until the acknowledge cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ph_q <= 2'h0;
            cnt_q <= 6'h00;
        end else if (ph_q == 2'h0) begin
            ph_q <= go_i ? 2'h1 : 2'h0;
        end else if (ph_q == 2'h1) begin
            ph_q <= 2'h2;
            cnt_q <= 6'h00;
        end else if (cnt_q == wait_i) begin
            ph_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // released lines fall to zero, the bus being an or of drivers
    always_comb begin
        bus_o = '0;
        mst_o = '0;
        busy_o = ph_q != 2'h0;
        mst_o[0].request = ph_q == 2'h1;
        mst_o[0].grant = ph_q == 2'h1; // only a requester is granted
        if (ph_q == 2'h2) begin
            mst_o[0].master_select = 1'b1;
            mst_o[0].be = be_i;
            bus_o.ctrl.select = 1'b1;
            bus_o.ctrl.be = be_i;
            bus_o.abus = addr_i;
            bus_o.wr_dbus = addr_i;
            bus_o.ctrl.xfer_ack = cnt_q == wait_i;
        end
    end
endmodule : pbm_bus_model

//--- tb/tb.sv
// self-checking bench of the bus protocol monitor
`timescale 1ns/1ps
module tb
    import pbm_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic go = 1'b0;
    logic busy;
    logic trig_any = 1'b0;
    logic trig;
    logic [CODE_W-1:0] code;
    logic [GRP_W-1:0] gen = '0;
    logic [63:0] seen = '0;
    logic [5:0] wt = 6'h04;
    logic [3:0] be = 4'hf;
    pbm_bus_t mdl_b, b, inj_b = '0;
    pbm_mst_t [N_MST-1:0] mdl_m, m, inj_m = '0;
    pbm_match_cfg_t [N_UNIT-1:0] cfg = '0;
    int n_fail = 0;
    int compares = 0;

    // --------------------------------------------------------------
    // parts
    // --------------------------------------------------------------
    initial forever #10 clk_i = ~clk_i;

    // injected faults are or-ed onto the bus, like any other driver
    pbm_bus_model mdl (.clk_i(clk_i), .srst_i(srst_i), .go_i(go),
        .wait_i(wt), .be_i(be), .addr_i(32'h1000), .busy_o(busy),
        .bus_o(mdl_b), .mst_o(mdl_m));
    pbm_monitor uut (.clk_i(clk_i), .srst_i(srst_i),
        .bus_i(pbm_bus_t'(mdl_b | inj_b)), .mst_i(mdl_m | inj_m),
        .generic_trigger_input_i(gen), .cfg_i(cfg), .trig_any_i(trig_any),
        .violation_code_o(code), .trigger_output_o(trig));

    // remember every code shown since the last clear
    always @(posedge clk_i) if (!srst_i) seen[code] = 1'b1;

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task chk(input string nm, input logic [63:0] got, input logic [63:0] e);
        compares++;
        if (got !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, got);
        end
    endtask : chk

    // optional transfer, pattern b/m injected for len cycles mid-way
    task run(input logic x, input logic [5:0] w, input logic [3:0] bv,
             input int len, input logic [5:0] c);
        int k;
        @(posedge clk_i);
        seen = '0;
        go <= x;
        wt <= w;
        be <= bv;
        @(posedge clk_i);
        go <= 1'b0;
        if (x) repeat (3) @(posedge clk_i);
        if (len > 0) begin
            inj_b <= b;
            inj_m <= m;
            repeat (len) @(posedge clk_i);
            inj_b <= '0;
            inj_m <= '0;
        end
        for (k = 0; k < 40 && busy; k++) @(posedge clk_i);
        if (k == 40) n_fail++; // a hung transfer counts as a mismatch
        repeat (3) @(posedge clk_i);
        #1;
        if (c == CODE_NONE) chk("codes", seen, 64'h1 << 63);
        else chk("code", 64'(seen[c]), 64'h1);
        b = '0;
        m = '0;
    endtask : run

    // one-cycle group values, trigger expected 15 cycles on
    task trg(input logic [31:0] rd, input logic [31:0] wr,
             input logic [31:0] g, input logic e);
        @(posedge clk_i);
        b.rd_dbus = rd;
        b.wr_dbus = wr;
        inj_b <= b;
        gen <= g;
        @(posedge clk_i);
        inj_b <= '0;
        gen <= '0;
        repeat (13) @(posedge clk_i);
        #1 chk("trig_early", 64'(trig), 64'h0);
        @(posedge clk_i);
        #1 chk("trig", 64'(trig), 64'(e));
        @(posedge clk_i);
        #1 chk("trig_late", 64'(trig), 64'h0);
        b = '0;
    endtask : trg

    task print_verdict;
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // --------------------------------------------------------------
    // sequence
    // --------------------------------------------------------------
    initial begin
        cfg[0] = '{1'b1, GRP_DATA, 32'h11, 32'hffffffff};
        cfg[1] = '{1'b1, GRP_GEN, 32'h5, 32'h5};
        b = '0;
        m = '0;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        run(1'b1, 6'h10, 4'hf, 0, 6'h3f);
        run(1'b1, 6'h11, 4'hf, 0, 6'h16);
        run(1'b1, 6'h04, 4'h2, 0, 6'h1e);
        run(1'b1, 6'h04, 4'h5, 0, 6'h1f);
        b.wr_dbus = 32'h1;
        run(1'b1, 6'h04, 4'hf, 1, 6'h1a);
        b.abus = 32'h100;
        run(1'b1, 6'h04, 4'hf, 1, 6'h19);
        b.ctrl.rnw = 1'b1;
        run(1'b1, 6'h04, 4'hf, 1, 6'h1b);
        b.ctrl.be = 4'h2;
        run(1'b1, 6'h04, 4'h1, 1, 6'h1d);
        b.ctrl.retry = 1'b1;
        b.ctrl.xfer_ack = 1'b1;
        run(1'b1, 6'h04, 4'hf, 1, 6'h04);
        b.ctrl.retry = 1'b1;
        run(1'b1, 6'h06, 4'hf, 2, 6'h07);
        b.ctrl.retry = 1'b1;
        run(1'b1, 6'h06, 4'hf, 1, 6'h08);
        b.abus = 32'h1;
        b.wr_dbus = 32'h1;
        b.ctrl.xfer_ack = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h0c);
        b.rd_dbus = 32'h8;
        run(1'b0, 6'h04, 4'hf, 1, 6'h0d);
        b.ctrl.xfer_ack = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h15);
        b.ctrl.err_ack = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h17);
        b.ctrl.retry = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h09);
        b.ctrl.rnw = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h10);
        b.ctrl.tout_sup = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h18);
        b.ctrl.timeout = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h0b);
        m[0] = 11'h600;
        m[1] = 11'h600;
        run(1'b0, 6'h04, 4'hf, 1, 6'h00);
        m[2].grant = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h01);
        b.ctrl.bus_lock = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h02);
        m[3].master_select = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h0e);
        b.ctrl.seq_addr = 1'b1;
        run(1'b0, 6'h04, 4'hf, 1, 6'h11);
        b.ctrl.seq_addr = 1'b1;
        b.ctrl.bus_lock = 1'b1;
        run(1'b1, 6'h04, 4'hf, 1, 6'h14);
        trg(32'h10, 32'h01, 32'h5, 1'b1);
        trg(32'h10, 32'h00, 32'h5, 1'b0);
        trg(32'h10, 32'h01, 32'h0, 1'b0);
        // any-of mode: one hitting unit is enough
        @(posedge clk_i);
        trig_any <= 1'b1;
        trg(32'h10, 32'h01, 32'h0, 1'b1);
        print_verdict;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        print_verdict;
    end
endmodule : tb
